// ### hw/phb_bridge.sv
// Host window decode, PCI cycle setup, channel decode and write gathering.
`timescale 1ns/10ps
module phb_bridge #(
    parameter logic [3:0] AGENT_ID = 4'h0
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [2:0] io_steps,
    input wire logic [1:0] sram_size_sel,
    input wire logic host_req,
    input wire logic [39:0] host_addr,
    input wire logic [1:0] host_size,
    input wire logic host_write,
    input wire logic [31:0] host_wdata,
    output logic host_ready,
    output logic host_done,
    output logic [31:0] host_rdata,
    output logic pci_cyc_valid,
    output phb_pkg::phb_kind_e pci_kind,
    output logic [31:0] pci_addr,
    output logic [3:0] pci_be_n,
    output logic pci_write,
    output logic [31:0] pci_wdata,
    input wire logic pci_done,
    input wire logic [31:0] pci_rdata,
    input wire logic build_req,
    input wire logic [9:0] build_chan,
    input wire logic [31:0] build_data,
    output logic build_err,
    output logic ctx_we,
    output logic [20:0] ctx_addr,
    output logic [31:0] ctx_wdata,
    output logic pf_req,
    output logic [9:0] pf_chan,
    input wire logic pci_clk,
    input wire logic tgt_valid,
    input wire logic [31:0] tgt_addr,
    input wire logic tgt_write,
    input wire logic [31:0] tgt_wdata,
    input wire logic [3:0] tgt_be,
    input wire logic tgt_flush,
    output logic ch_valid,
    output logic [9:0] ch_num,
    output logic [21:0] ch_off,
    output logic ch_sram,
    output logic ch_reject,
    output logic fl_valid,
    output logic [9:0] fl_chan,
    output logic [16:0] fl_line,
    output logic [255:0] fl_data,
    output logic [31:0] fl_mask
);
    import phb_pkg::*;

    // Host side, on ref_clk.
    wire [28:0] off = host_addr[28:0];
    wire in_win = host_addr[39:34] == HWIN_TAG;
    wire for_me = host_addr[AGT_LSB+3:AGT_LSB] == AGENT_ID;
    wire is_cfg = off <= CFG_LAST;
    wire [2:0] idx = off[28:STEP_LSB];
    wire in_split = (idx != 3'h0) && (idx <= SPLIT_STEPS);
    wire [2:0] io_lim = (io_steps > SPLIT_STEPS) ? SPLIT_STEPS : io_steps;
    wire is_io = in_split && ((idx - 3'h1) < io_lim);
    wire is_mem = in_split && !is_io;
    wire dev_ok = (host_addr[23:16] != 8'h00) ||
        (host_addr[15:11] <= BUS0_DEV_LAST);
    wire sz_ok = host_size != SZ_DWORD;
    wire [3:0] be_base = (host_size == SZ_BYTE) ? 4'h1 :
        (host_size == SZ_HALF) ? 4'h3 : 4'hF;
    wire [3:0] be = 4'(be_base << off[1:0]);
    wire [31:0] cfg_a = {8'h00, off[23:2], 2'b00};
    wire [31:0] io_a = {3'b000, 29'(off - SPLIT_BASE)};
    wire [31:0] mem_sum = 32'({3'b000, off} + MEM_BIAS);
    wire [31:0] mem_a = {mem_sum[31:2], 2'b00};
    wire take = ce && host_req && host_ready && in_win && for_me;
    wire mapped = (is_cfg && dev_ok) || is_io || is_mem;
    wire go_pci = take && sz_ok && mapped;
    wire go_void = take && !go_pci;

    phb_state_e state_r;
    assign host_ready = state_r == ST_IDLE;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            pci_cyc_valid <= 1'b0;
            host_done <= 1'b0;
        end else if (ce) begin
            pci_cyc_valid <= go_pci;
            host_done <= go_void || (state_r == ST_PCI && pci_done);
            case (state_r)
                ST_IDLE: begin
                    if (go_pci) begin
                        state_r <= ST_PCI;
                    end
                end
                ST_PCI: begin
                    if (pci_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pci_kind <= KIND_CFG;
            pci_addr <= 32'h00000000;
            pci_be_n <= 4'hF;
            pci_write <= 1'b0;
            pci_wdata <= 32'h00000000;
            host_rdata <= 32'h00000000;
        end else if (ce) begin
            if (go_pci) begin
                pci_kind <= is_cfg ? KIND_CFG : is_io ? KIND_IO : KIND_MEM;
                pci_addr <= is_cfg ? cfg_a : is_io ? io_a : mem_a;
                pci_be_n <= ~be;
                pci_write <= host_write;
                pci_wdata <= host_wdata;
            end
            if (go_void) begin
                host_rdata <= RD_FIXED;
            end else if (state_r == ST_PCI && pci_done) begin
                host_rdata <= pci_rdata;
            end
        end
    end

    // Channel build: one context word per channel, 64 bytes apart, keeps
    // all 1008 contexts inside the lowest 64 kilobytes of the SRAM.
    wire build_ok = build_chan < CH_RSV_FIRST;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctx_we <= 1'b0;
            pf_req <= 1'b0;
            build_err <= 1'b0;
            ctx_addr <= 21'h000000;
            ctx_wdata <= 32'h00000000;
            pf_chan <= 10'h000;
        end else if (ce) begin
            ctx_we <= build_req && build_ok;
            pf_req <= build_req && build_ok;
            build_err <= build_req && !build_ok;
            if (build_req && build_ok) begin
                ctx_addr <= {5'h00, build_chan, 6'h00};
                ctx_wdata <= build_data;
                pf_chan <= build_chan;
            end
        end
    end

    // Crossings into pci_clk. The split and SRAM size are quasi-static;
    // software must not change them while PCI traffic is in flight.
    logic rst_m, p_rst, ce_m, p_ce;
    logic [2:0] io_m, io_p;
    logic [1:0] sz_m, sz_p;
    always_ff @(posedge pci_clk) begin
        rst_m <= srst;
        p_rst <= rst_m;
        ce_m <= ce;
        p_ce <= ce_m;
        io_m <= io_steps;
        io_p <= io_m;
        sz_m <= sram_size_sel;
        sz_p <= sz_m;
    end

    wire [9:0] ch = tgt_addr[31:CH_LSB];
    wire [2:0] io_lim_p = (io_p > SPLIT_STEPS) ? SPLIT_STEPS : io_p;
    wire [2:0] mem_steps = SPLIT_STEPS - io_lim_p;
    wire [9:0] ch_limit = CH_RSV_FIRST - {3'b000, mem_steps, 4'h0};
    wire [20:0] sram_last = 21'(SRAM_MIN_LAST << sz_p);
    wire direct = ch == CH_SRAM;
    wire rej = direct ? (tgt_addr[21:0] > {1'b0, sram_last}) :
        (ch >= ch_limit);
    wire dma_wr = p_ce && tgt_valid && tgt_write && !rej && !direct;

    always_ff @(posedge pci_clk) begin
        if (p_rst) begin
            ch_valid <= 1'b0;
            ch_reject <= 1'b0;
            ch_sram <= 1'b0;
            ch_num <= 10'h000;
            ch_off <= 22'h000000;
        end else if (p_ce) begin
            ch_valid <= tgt_valid && !rej;
            ch_reject <= tgt_valid && rej;
            if (tgt_valid) begin
                ch_num <= ch;
                ch_off <= tgt_addr[CH_LSB-1:0];
                ch_sram <= direct;
            end
        end
    end

    // Write gathering: one open line at a time. A write to another line,
    // or a flush request in a cycle with no write to the open line, pushes
    // the open line out first; no state is kept per channel, so interleaved
    // channels flush partial lines.
    wire [26:0] tag = tgt_addr[31:LINE_LSB];
    logic [26:0] tag_r, fl_tag;
    logic have_r;
    logic [31:0] mask_r;
    logic [31:0] hit;
    logic [7:0] line_b [LINE_BYTES];
    logic [7:0] fl_b [LINE_BYTES];
    wire same = have_r && (tag == tag_r);
    wire flush_old = have_r && (dma_wr ? !same : (p_ce && tgt_flush));
    wire [31:0] mask_m = (same ? mask_r : 32'h00000000) | hit;
    wire full = dma_wr && (&mask_m);

    genvar b;
    generate
        for (b = 0; b < LINE_BYTES; b++) begin : g_byte
            assign hit[b] = dma_wr && (tgt_addr[4:2] == 3'(b / 4)) &&
                tgt_be[b % 4];
            assign fl_data[b*8 +: 8] = fl_b[b];
            always_ff @(posedge pci_clk) begin
                if (hit[b]) begin
                    line_b[b] <= tgt_wdata[(b % 4)*8 +: 8];
                end
                if (p_ce && flush_old) begin
                    fl_b[b] <= line_b[b];
                end else if (full) begin
                    fl_b[b] <= hit[b] ? tgt_wdata[(b % 4)*8 +: 8] :
                        line_b[b];
                end
            end
        end
    endgenerate

    assign fl_chan = fl_tag[26:17];
    assign fl_line = fl_tag[16:0];

    always_ff @(posedge pci_clk) begin
        if (p_rst) begin
            have_r <= 1'b0;
            mask_r <= 32'h00000000;
            tag_r <= 27'h0000000;
            fl_valid <= 1'b0;
            fl_tag <= 27'h0000000;
            fl_mask <= 32'h00000000;
        end else if (p_ce) begin
            fl_valid <= flush_old || full;
            if (flush_old) begin
                fl_tag <= tag_r;
                fl_mask <= mask_r;
            end else if (full) begin
                fl_tag <= tag;
                fl_mask <= mask_m;
            end
            if (full) begin
                have_r <= 1'b0;
                mask_r <= 32'h00000000;
            end else if (dma_wr) begin
                have_r <= 1'b1;
                mask_r <= mask_m;
                tag_r <= tag;
            end else if (flush_old) begin
                have_r <= 1'b0;
                mask_r <= 32'h00000000;
            end
        end
    end

    // Checks on the ref_clk side. The block has two clock domains, so each
    // property names its own clock and reset.

    sequence s_take;
        ce && host_req && host_ready && in_win && for_me;
    endsequence
    sequence s_cfg;
        s_take ##0 (is_cfg && dev_ok && sz_ok);
    endsequence
    sequence s_io;
        s_take ##0 (is_io && sz_ok);
    endsequence

    property p_win;
        @(posedge ref_clk) disable iff (srst)
        ce && host_req && host_ready && !in_win |=>
            !pci_cyc_valid && !host_done;
    endproperty
    a_win: assert property (p_win) else $error("window miss acted");

    property p_agent;
        @(posedge ref_clk) disable iff (srst)
        ce && host_req && host_ready && in_win && !for_me |=>
            !pci_cyc_valid;
    endproperty
    a_agent: assert property (p_agent)
        else $error("foreign agent access started a cycle");

    property p_cfg;
        @(posedge ref_clk) disable iff (srst)
        s_cfg |=> pci_cyc_valid && pci_kind == KIND_CFG &&
            pci_addr[23:2] == $past(host_addr[23:2]);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config cycle address wrong");

    property p_dev;
        @(posedge ref_clk) disable iff (srst)
        s_take ##0 (is_cfg && host_addr[23:16] == 8'h00 &&
            host_addr[15:11] > BUS0_DEV_LAST)
            |=> host_done && !pci_cyc_valid && host_rdata == RD_FIXED;
    endproperty
    a_dev: assert property (p_dev)
        else $error("absent bus zero device not refused");

    property p_be;
        @(posedge ref_clk) disable iff (srst)
        s_cfg ##0 (host_size == SZ_BYTE) |=>
            pci_be_n == ~4'(4'h1 << $past(host_addr[1:0]));
    endproperty
    a_be: assert property (p_be) else $error("byte enable wrong");

    property p_dword;
        @(posedge ref_clk) disable iff (srst)
        s_take ##0 (host_size == SZ_DWORD) |=>
            !pci_cyc_valid && host_done ##1 host_ready;
    endproperty
    a_dword: assert property (p_dword)
        else $error("64-bit access reached PCI");

    property p_io;
        @(posedge ref_clk) disable iff (srst)
        s_io |=> pci_kind == KIND_IO &&
            pci_addr == {3'b000, 29'($past(off) - SPLIT_BASE)};
    endproperty
    a_io: assert property (p_io) else $error("I/O address wrong");

    property p_mem;
        @(posedge ref_clk) disable iff (srst)
        pci_cyc_valid && pci_kind == KIND_MEM |-> pci_addr[1:0] == 2'b00;
    endproperty
    a_mem: assert property (p_mem)
        else $error("memory address not word aligned");

    property p_build;
        @(posedge ref_clk) disable iff (srst)
        ce && build_req && build_chan < CH_RSV_FIRST |=>
            ctx_we && pf_req && ctx_addr[15:6] == $past(build_chan);
    endproperty
    a_build: assert property (p_build)
        else $error("channel build did not write context");

    // Checks on the pci_clk side.
    property p_chan;
        @(posedge pci_clk) disable iff (p_rst)
        p_ce && tgt_valid |=> (ch_valid || ch_reject) &&
            ch_num == $past(tgt_addr[31:22]) &&
            ch_off == $past(tgt_addr[21:0]);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel split wrong");

    property p_rsv;
        @(posedge pci_clk) disable iff (p_rst)
        p_ce && tgt_valid && tgt_addr[31:22] >= CH_RSV_FIRST &&
            tgt_addr[31:22] != CH_SRAM |=> ch_reject && !ch_valid;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved channel accepted");

    property p_full;
        @(posedge pci_clk) disable iff (p_rst)
        full |=> fl_valid && fl_mask == 32'hFFFFFFFF && !have_r;
    endproperty
    a_full: assert property (p_full)
        else $error("full line not flushed");
endmodule // phb_bridge

// ### include/phb_pkg.sv
// Constants and types for the host-to-PCI bridge address map.
package phb_pkg;
    localparam logic [5:0] HWIN_TAG = 6'h3E;
    localparam int unsigned AGT_LSB = 30;
    localparam logic [28:0] CFG_LAST = 29'h0FFFFFF;
    localparam logic [28:0] SPLIT_BASE = 29'h4000000;
    localparam logic [2:0] SPLIT_STEPS = 3'h6;
    localparam int unsigned STEP_LSB = 26;
    localparam logic [31:0] MEM_BIAS = 32'hE3C00000;
    localparam logic [31:0] RD_FIXED = 32'hFFFFFFFF;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h3;
    localparam logic [4:0] BUS0_DEV_LAST = 5'h03;
    localparam logic [9:0] CH_RSV_FIRST = 10'h3F0;
    localparam logic [9:0] CH_SRAM = 10'h3FF;
    localparam int unsigned CH_LSB = 22;
    localparam int unsigned LINE_LSB = 5;
    localparam int unsigned LINE_BYTES = 32;
    localparam logic [20:0] SRAM_MIN_LAST = 21'h03FFFF;
    typedef enum logic [1:0] {KIND_CFG, KIND_IO, KIND_MEM} phb_kind_e;
    typedef enum logic {ST_IDLE, ST_PCI} phb_state_e;
endpackage

// ### tb/phb_pci_model.sv
// Behavioural PCI bus controller that answers cycles started by the bridge.
`timescale 1ns/10ps
module phb_pci_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic pci_cyc_valid,
    input wire logic [31:0] pci_addr,
    output logic pci_done,
    output logic [31:0] pci_rdata
);
    int unsigned wait_n;

    initial begin
        pci_done = 1'b0;
        pci_rdata = 32'h0;
    end

    // A busy target is modelled by extra wait states before completion.
    always @(posedge ref_clk) begin
        if (pci_cyc_valid === 1'b1) begin
            wait_n = slow ? 5 : 1;
            repeat (wait_n) @(negedge ref_clk);
            pci_done = 1'b1;
            pci_rdata = pci_addr ^ 32'hA5A50000;
            @(negedge ref_clk);
            pci_done = 1'b0;
            // Released read data must not look like a held value.
            pci_rdata = ~pci_rdata;
        end
    end
endmodule // phb_pci_model

// ### tb/test_pci_host_bridge_address_map.sv
// Self-checking bench for the host-to-PCI bridge address map.
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_pci_host_bridge_address_map;
    import phb_pkg::*;
    logic ref_clk = 0, pci_clk = 0, srst = 1, ce = 1, slow = 0;
    logic [2:0] io_steps = 3'h3;
    logic [1:0] sram_size_sel = 2'h0, host_size = 2'h0;
    logic host_req = 0, host_write = 0, build_req = 0;
    logic [39:0] host_addr = 40'h0;
    logic [31:0] host_wdata = 32'h0, build_data = 32'h0, host_rdata;
    logic [9:0] build_chan = 10'h0;
    logic tgt_valid = 0, tgt_write = 0, tgt_flush = 0;
    logic [31:0] tgt_addr = 32'h0, tgt_wdata = 32'h0;
    logic [3:0] tgt_be = 4'h0, pci_be_n;
    logic host_ready, host_done, pci_cyc_valid, pci_write, pci_done;
    logic [31:0] pci_addr, pci_wdata, pci_rdata, ctx_wdata, fl_mask;
    logic build_err, ctx_we, pf_req, ch_valid, ch_sram, ch_reject;
    logic [20:0] ctx_addr;
    logic [9:0] pf_chan, ch_num, fl_chan;
    logic [21:0] ch_off;
    logic fl_valid;
    logic [16:0] fl_line;
    logic [255:0] fl_data, exp_line;
    phb_kind_e pci_kind;
    logic saw_cyc, saw_done, saw_busy;
    logic [5:0] win_tag = HWIN_TAG;
    int err_total = 0, n_checks = 0;

    phb_bridge phb_bridge_i (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .io_steps(io_steps), .sram_size_sel(sram_size_sel),
        .host_req(host_req), .host_addr(host_addr), .host_size(host_size),
        .host_write(host_write), .host_wdata(host_wdata),
        .host_ready(host_ready), .host_done(host_done),
        .host_rdata(host_rdata), .pci_cyc_valid(pci_cyc_valid),
        .pci_kind(pci_kind), .pci_addr(pci_addr), .pci_be_n(pci_be_n),
        .pci_write(pci_write), .pci_wdata(pci_wdata), .pci_done(pci_done),
        .pci_rdata(pci_rdata), .build_req(build_req),
        .build_chan(build_chan), .build_data(build_data),
        .build_err(build_err), .ctx_we(ctx_we), .ctx_addr(ctx_addr),
        .ctx_wdata(ctx_wdata), .pf_req(pf_req), .pf_chan(pf_chan),
        .pci_clk(pci_clk), .tgt_valid(tgt_valid), .tgt_addr(tgt_addr),
        .tgt_write(tgt_write), .tgt_wdata(tgt_wdata), .tgt_be(tgt_be),
        .tgt_flush(tgt_flush), .ch_valid(ch_valid), .ch_num(ch_num),
        .ch_off(ch_off), .ch_sram(ch_sram), .ch_reject(ch_reject),
        .fl_valid(fl_valid), .fl_chan(fl_chan), .fl_line(fl_line),
        .fl_data(fl_data), .fl_mask(fl_mask));

    phb_pci_model phb_pci_model_i (.ref_clk(ref_clk), .slow(slow),
        .pci_cyc_valid(pci_cyc_valid), .pci_addr(pci_addr),
        .pci_done(pci_done), .pci_rdata(pci_rdata));

    always #25 ref_clk = ~ref_clk;

    // The link clock starts off an odd offset so the domains never align.
    initial begin
        #17;
        forever #80 pci_clk = ~pci_clk;
    end

    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic host_acc(input logic [3:0] agt, input logic [28:0] off,
            input logic [1:0] sz);
        @(negedge ref_clk);
        host_req = 1'b1;
        // Callers pass only offsets aligned to the access size.
        host_addr = {win_tag, agt, 1'b0, off};
        host_size = sz;
        host_write = (sz == SZ_BYTE);
        host_wdata = {3'h0, off};
        // The start pulse stands one cycle, so look just after the edge
        // that takes the request.
        @(posedge ref_clk);
        #1;
        saw_cyc = (pci_cyc_valid === 1'b1);
        saw_busy = (host_ready === 1'b0);
        saw_done = (host_done === 1'b1);
        @(negedge ref_clk);
        host_req = 1'b0;
        host_addr = ~host_addr;
        for (int i = 0; i < 12 && !saw_done; i++) begin
            @(posedge ref_clk);
            #1;
            if (pci_cyc_valid === 1'b1) begin
                saw_cyc = 1'b1;
            end
            saw_done = (host_done === 1'b1);
        end
    endtask

    task automatic expect_pci(input phb_kind_e k, input logic [31:0] a,
            input logic [3:0] ben_n);
        `CHK(saw_cyc, 1'b1)
        `CHK(saw_busy, 1'b1)
        `CHK(saw_done, 1'b1)
        `CHK(pci_kind, k)
        `CHK(pci_addr, a)
        `CHK(pci_be_n, ben_n)
        `CHK(host_rdata, a ^ 32'hA5A50000)
    endtask

    task automatic expect_refused(input logic done_exp);
        `CHK(saw_cyc, 1'b0)
        `CHK(saw_busy, 1'b0)
        `CHK(saw_done, done_exp)
        if (done_exp) `CHK(host_rdata, RD_FIXED)
    endtask

    task automatic build(input logic [9:0] ch, input logic ok);
        @(negedge ref_clk);
        build_req = 1'b1;
        build_chan = ch;
        build_data = {22'h0, ch};
        @(posedge ref_clk);
        #1;
        `CHK(ctx_we, ok)
        `CHK(pf_req, ok)
        `CHK(build_err, !ok)
        if (ok) `CHK(ctx_addr, {5'h0, ch, 6'h00})
        if (ok) `CHK(ctx_wdata, {22'h0, ch})
        if (ok) `CHK(pf_chan, ch)
        @(negedge ref_clk);
        build_req = 1'b0;
    endtask

    // A build offered while the clock enable is low must leave no trace.
    task automatic frozen_build(input logic [9:0] ch);
        @(negedge ref_clk);
        ce = 1'b0;
        build_req = 1'b1;
        build_chan = ch;
        build_data = {22'h0, ch};
        @(posedge ref_clk);
        #1;
        `CHK(ctx_we, 1'b0)
        `CHK(pf_req, 1'b0)
        `CHK(build_err, 1'b0)
        @(negedge ref_clk);
        ce = 1'b1;
        build_req = 1'b0;
    endtask

    task automatic tgt_rd(input logic [31:0] a, input logic acc,
            input logic sr);
        @(negedge pci_clk);
        tgt_valid = 1'b1;
        // One controller model drives every access, so no channel is shared.
        tgt_addr = a;
        tgt_write = 1'b0;
        @(posedge pci_clk);
        #1;
        `CHK(ch_valid, acc)
        `CHK(ch_reject, !acc)
        if (acc) `CHK(ch_num, a[31:22])
        if (acc) `CHK(ch_off, a[21:0])
        if (acc) `CHK(ch_sram, sr)
        @(negedge pci_clk);
        tgt_valid = 1'b0;
        tgt_addr = ~a;
    endtask

    task automatic tgt_wr(input logic [31:0] a, input logic [3:0] be,
            input logic [31:0] d);
        @(negedge pci_clk);
        tgt_valid = 1'b1;
        tgt_addr = a;
        tgt_write = 1'b1;
        tgt_be = be;
        tgt_wdata = d;
        @(negedge pci_clk);
        tgt_valid = 1'b0;
        tgt_wdata = ~d;
    endtask

    task automatic wait_fl;
        for (int i = 0; i < 4 && fl_valid !== 1'b1; i++) begin
            @(posedge pci_clk);
            #1;
        end
        `CHK(fl_valid, 1'b1)
        `CHK(fl_chan, 10'd5)
    endtask

    initial begin
        #3000000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        repeat (4) @(posedge pci_clk);
        host_acc(4'h0, 29'h00015AA, SZ_HALF);
        expect_pci(KIND_CFG, 32'h000015A8, 4'h3);
        host_acc(4'h0, 29'h0074804, 2'h2);
        expect_pci(KIND_CFG, 32'h00074804, 4'h0);
        host_acc(4'h0, 29'h0001503, SZ_BYTE);
        expect_pci(KIND_CFG, 32'h00001500, 4'h7);
        host_acc(4'h0, 29'h0002000, SZ_HALF);
        expect_refused(1'b1);
        host_acc(4'h0, 29'h0000000, SZ_DWORD);
        expect_refused(1'b1);
        host_acc(4'h0, 29'h1000000, 2'h2);
        expect_refused(1'b1);
        host_acc(4'h0, 29'h1C000000, 2'h2);
        expect_refused(1'b1);
        host_acc(4'h1, 29'h00015A8, 2'h2);
        expect_refused(1'b0);
        win_tag = 6'h3F;
        host_acc(4'h0, 29'h00015A8, 2'h2);
        expect_refused(1'b0);
        win_tag = HWIN_TAG;
        slow = 1'b1;
        host_acc(4'h0, 29'h4000001, SZ_BYTE);
        expect_pci(KIND_IO, 32'h00000001, 4'hD);
        `CHK(pci_write, 1'b1)
        `CHK(pci_wdata, 32'h04000001)
        host_acc(4'h0, 29'h0FFFFFFF, SZ_BYTE);
        expect_pci(KIND_IO, 32'h0BFFFFFF, 4'h7);
        slow = 1'b0;
        host_acc(4'h0, 29'h10000002, SZ_HALF);
        expect_pci(KIND_MEM, 32'hF3C00000, 4'h3);
        host_acc(4'h0, 29'h1BFFFFFC, 2'h2);
        expect_pci(KIND_MEM, 32'hFFBFFFFC, 4'h0);
        build(10'd5, 1'b1);
        build(10'd1007, 1'b1);
        build(10'd1008, 1'b0);
        frozen_build(10'd6);
        tgt_rd({10'd0, 22'h001234}, 1'b1, 1'b0);
        tgt_rd({10'd959, 22'h3FFFFC}, 1'b1, 1'b0);
        tgt_rd({10'd960, 22'h000000}, 1'b0, 1'b0);
        tgt_rd({10'd1010, 22'h000010}, 1'b0, 1'b0);
        tgt_rd({10'd1023, 22'h000100}, 1'b1, 1'b1);
        tgt_rd({10'd1023, 22'h040000}, 1'b0, 1'b0);
        // Writes stay on one line of channel 5 so only a full line flushes.
        for (int i = 0; i < 8; i++) begin
            exp_line[32*i +: 32] = 32'h11110000 + i;
            tgt_wr({10'd5, 22'h000040} + 4 * i, 4'hF, 32'h11110000 + i);
        end
        wait_fl();
        `CHK(fl_mask, 32'hFFFFFFFF)
        `CHK(fl_line, 17'h00002)
        `CHK(fl_data, exp_line)
        tgt_wr({10'd5, 22'h000080}, 4'h3, 32'h0000BEEF);
        @(negedge pci_clk);
        tgt_flush = 1'b1;
        @(negedge pci_clk);
        tgt_flush = 1'b0;
        wait_fl();
        `CHK(fl_mask, 32'h00000003)
        `CHK(fl_line, 17'h00004)
        `CHK(fl_data[15:0], 16'hBEEF)
        close_out();
    end
endmodule // test_pci_host_bridge_address_map
